// [hdl/tft_timing_pkg.sv]
// Purpose: Constants shared by the TFT panel timing generator.
// Assumes: Byte offsets on an 8-bit register address, 32-bit data.
// Notes:   Timing counts are in pixel clock periods or in lines.
package tft_timing_pkg;

	// ********************************************************
	// Register offsets
	// ********************************************************
	localparam logic [7:0] OFS_PANEL_TYPE   = 8'h0c;
	localparam logic [7:0] OFS_HTOTAL       = 8'h20;
	localparam logic [7:0] OFS_HDISP_PERIOD = 8'h24;
	localparam logic [7:0] OFS_HDISP_START  = 8'h28;
	localparam logic [7:0] OFS_HSYNC        = 8'h2c;
	localparam logic [7:0] OFS_VTOTAL       = 8'h30;
	localparam logic [7:0] OFS_VDISP_PERIOD = 8'h34;
	localparam logic [7:0] OFS_VDISP_START  = 8'h38;
	localparam logic [7:0] OFS_VSYNC        = 8'h3c;
	localparam logic [7:0] OFS_STATUS       = 8'h40;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int POS_WIDTH     = 16;
	localparam int POS_POLARITY  = 23;
	localparam int POS_DIRECT    = 4;
	localparam int POS_LINE_STAT = 16;

	// ********************************************************
	// Encodings and reset values
	// ********************************************************
	localparam logic [1:0]  PANEL_TFT       = 2'h1;
	localparam logic [31:0] REG_RESET       = 32'h0000_0000;

	// ********************************************************
	// Timing counts
	// ********************************************************
	localparam logic [11:0] GROUP_PIXELS    = 12'h008;
	localparam logic [11:0] HSTART_ADD      = 12'h001;
	localparam logic [11:0] HDISP_ADD       = 12'h005;
	localparam logic [11:0] DE_MAX_DELAY    = 12'h0fa;
	localparam logic [11:0] AUX3_DELAY      = 12'h004;
	localparam logic [11:0] AUX3_WIDTH      = 12'h001;
	localparam logic [11:0] AUX_LEAD        = 12'h004;
	localparam logic [11:0] AUX_MAIN_WIDTH  = 12'h088;
	localparam logic [11:0] AUX2_LEAD       = 12'h00a;
	localparam logic [11:0] AUX1_ALT_WIDTH  = 12'h030;
	localparam logic [11:0] AUX1_ALT_GAP    = 12'h028;
	localparam logic [11:0] AUX0_ALT_WIDTH  = 12'h018;
	localparam logic [11:0] AUX1_ALT_LINE   = 12'h005;
	localparam logic [11:0] AUX1_ALT_LINES  = 12'h004;
	localparam logic [11:0] AUX0_ALT_LINE   = 12'h028;
	localparam logic [11:0] AUX0_ALT_LINES  = 12'h0a2;

	typedef logic [11:0] cnt_t;

endpackage

// [hdl/tft_panel_timing_generator.sv]
// Purpose: Frame, line, data-enable and shift clock timing for TFT panels,
//          plus per-line auxiliary pulses for direct reflective panels.
// Assumes: Pixel clock arrives as a pin slower than a third of sys_clk.
// Notes:   Panel outputs other than the shift clock step once per sampled pixel clock rise.
//
// Notes on behaviour
// - Vertical total is field plus one lines
// - Vsync starts at field line, no offset
// - Vsync lasts width field plus one lines
// - Vertical display starts at field line
// - Vertical display is field plus one lines
// - Horizontal total is (field plus one) times eight
// - Hsync starts at field plus one pixels
// - Hsync width is field plus one pixels
// - Horizontal display starts at field plus five
// - Display width is (field plus one) times eight
// - Panel type 01 selects TFT timing
// - Polarity bit zero makes syncs active low
// - Data enable follows hsync fall, wrapped delay
// - Data enable lasts display period, then waits
// - Vsync repeats per frame, edge leads hsync edge by the sync start
// - Hsync repeats every horizontal total pixels
// - Shift clock one pixel, even halves, data earlier
// - Aux 3 pulses 4 after hsync rise
// - Aux 1/0 complementary, 136 wide, lead 4
// - Aux 2 toggles 10 before hsync rise
// - Alternate aux timing at lines 5 and 40
// - Alternate aux 1: two 48-pixel pulses
// - Alternate aux 0: 24-pixel low pulse
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps

module tft_panel_timing_generator (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_we,
	input  wire logic        reg_re,
	output logic      [31:0] reg_rdata,
	input  wire logic        pixel_clock_in,
	output logic             horizontal_sync_out,
	output logic             vertical_sync_out,
	output logic             data_enable_out,
	output logic             panel_shift_clock,
	output logic             aux_control_0,
	output logic             aux_control_1,
	output logic             aux_control_2,
	output logic             aux_control_3
);

	// ********************************************************
	// State
	// ********************************************************
	typedef struct packed {
		logic [1:0]  panel_type;
		logic        direct_mode;
		logic [6:0]  htotal_f;
		logic [6:0]  hdisp_period_f;
		logic [9:0]  hdisp_start_f;
		logic [9:0]  hsync_start_f;
		logic [6:0]  hsync_width_f;
		logic        hsync_pol;
		logic [9:0]  vtotal_f;
		logic [9:0]  vdisp_period_f;
		logic [9:0]  vdisp_start_f;
		logic [9:0]  vsync_start_f;
		logic [2:0]  vsync_width_f;
		logic        vsync_pol;
		logic        pclk_meta;
		logic        pclk_sync;
		logic        pclk_last;
		logic [11:0] hcnt;
		logic [11:0] vcnt;
		logic        hsync;
		logic        vsync;
		logic        de;
		logic        shift;
		logic [3:0]  aux;
		logic [31:0] rdata;
	} state_s;

	state_s state_q;
	state_s state_d;

	// ********************************************************
	// Helpers
	// ********************************************************
	// Fold a value below twice the total back into range
	function automatic tft_timing_pkg::cnt_t wrap(
		input logic [12:0]          x,
		input tft_timing_pkg::cnt_t total
	);
		if (x >= {1'b0, total}) begin
			wrap = tft_timing_pkg::cnt_t'(x - {1'b0, total});
		end else begin
			wrap = x[11:0];
		end
	endfunction

	// Position offset forward or backward, modulo the total
	function automatic tft_timing_pkg::cnt_t shift_pos(
		input tft_timing_pkg::cnt_t base,
		input tft_timing_pkg::cnt_t fwd,
		input tft_timing_pkg::cnt_t back,
		input tft_timing_pkg::cnt_t total
	);
		tft_timing_pkg::cnt_t s;
		s = wrap({1'b0, base} + {1'b0, total} - {1'b0, back}, total);
		shift_pos = wrap({1'b0, s} + {1'b0, fwd}, total);
	endfunction

	// True while cnt lies in [start, start+len) on a circular count
	function automatic logic in_win(
		input tft_timing_pkg::cnt_t cnt,
		input tft_timing_pkg::cnt_t start,
		input tft_timing_pkg::cnt_t len,
		input tft_timing_pkg::cnt_t total
	);
		tft_timing_pkg::cnt_t d;
		d = wrap({1'b0, cnt} + {1'b0, total} - {1'b0, start}, total);
		in_win = (d < len);
	endfunction

	// ********************************************************
	// Derived timing
	// ********************************************************
	tft_timing_pkg::cnt_t h_total;
	tft_timing_pkg::cnt_t h_sync_at;
	tft_timing_pkg::cnt_t h_sync_len;
	tft_timing_pkg::cnt_t h_de_at;
	tft_timing_pkg::cnt_t h_de_len;
	tft_timing_pkg::cnt_t h_rise;
	tft_timing_pkg::cnt_t aux_at;
	tft_timing_pkg::cnt_t v_total;
	tft_timing_pkg::cnt_t v_line;
	logic                 pix_tick;
	logic                 tft_on;

	// Totals and windows from the programmed fields
	assign h_total    = (12'(state_q.htotal_f) + 12'h001)
	                    * tft_timing_pkg::GROUP_PIXELS;
	assign h_sync_at  = wrap(13'(state_q.hsync_start_f)
	                    + 13'(tft_timing_pkg::HSTART_ADD), h_total);
	assign h_sync_len = 12'(state_q.hsync_width_f) + 12'h001;
	assign h_de_at    = wrap(13'(state_q.hdisp_start_f)
	                    + 13'(tft_timing_pkg::HDISP_ADD), h_total);
	assign h_de_len   = (12'(state_q.hdisp_period_f) + 12'h001)
	                    * tft_timing_pkg::GROUP_PIXELS;
	assign v_total    = 12'(state_q.vtotal_f) + 12'h001;
	// Hsync trailing edge, where the aux pulses are anchored
	assign h_rise     = shift_pos(h_sync_at, h_sync_len, 12'h000, h_total);
	assign aux_at     = shift_pos(h_rise, 12'h000,
	                    tft_timing_pkg::AUX_LEAD, h_total);
	// Lines elapsed since the vsync leading edge
	assign v_line     = shift_pos(state_q.vcnt, 12'h000,
	                    12'(state_q.vsync_start_f), v_total);
	// Edge search reads only the second and third stages
	assign pix_tick   = state_q.pclk_sync & ~state_q.pclk_last;
	assign tft_on     = (state_q.panel_type == tft_timing_pkg::PANEL_TFT);

	// ********************************************************
	// Next state
	// ********************************************************
	always_comb begin
		logic act_h;
		logic act_v;
		logic vis_v;
		logic alt1;
		logic alt0;
		logic a1;
		logic a0;
		act_h = 1'b0;
		act_v = 1'b0;
		vis_v = 1'b0;
		alt1  = 1'b0;
		alt0  = 1'b0;
		a1    = 1'b0;
		a0    = 1'b0;
		state_d = state_q;

		// Pixel clock pin synchroniser
		state_d.pclk_meta = pixel_clock_in;
		state_d.pclk_sync = state_q.pclk_meta;
		state_d.pclk_last = state_q.pclk_sync;

		// Shift clock mirrors the pixel clock; outputs move on its rise,
		// half a period ahead of the fall the panel samples on
		state_d.shift = tft_on & state_q.pclk_sync;

		// Register write port
		if (reg_we) begin
			unique case (reg_addr)
			tft_timing_pkg::OFS_PANEL_TYPE: begin
				state_d.panel_type  = reg_wdata[1:0];
				state_d.direct_mode = reg_wdata[tft_timing_pkg::POS_DIRECT];
			end
			tft_timing_pkg::OFS_HTOTAL: begin
				state_d.htotal_f = reg_wdata[6:0];
			end
			tft_timing_pkg::OFS_HDISP_PERIOD: begin
				state_d.hdisp_period_f = reg_wdata[6:0];
			end
			tft_timing_pkg::OFS_HDISP_START: begin
				state_d.hdisp_start_f = reg_wdata[9:0];
			end
			tft_timing_pkg::OFS_HSYNC: begin
				state_d.hsync_start_f = reg_wdata[9:0];
				state_d.hsync_width_f =
					reg_wdata[tft_timing_pkg::POS_WIDTH +: 7];
				state_d.hsync_pol =
					reg_wdata[tft_timing_pkg::POS_POLARITY];
			end
			tft_timing_pkg::OFS_VTOTAL: begin
				state_d.vtotal_f = reg_wdata[9:0];
			end
			tft_timing_pkg::OFS_VDISP_PERIOD: begin
				state_d.vdisp_period_f = reg_wdata[9:0];
			end
			tft_timing_pkg::OFS_VDISP_START: begin
				state_d.vdisp_start_f = reg_wdata[9:0];
			end
			tft_timing_pkg::OFS_VSYNC: begin
				state_d.vsync_start_f = reg_wdata[9:0];
				state_d.vsync_width_f =
					reg_wdata[tft_timing_pkg::POS_WIDTH +: 3];
				state_d.vsync_pol =
					reg_wdata[tft_timing_pkg::POS_POLARITY];
			end
			default: begin
			end
			endcase
		end

		// Read data stands for one cycle only; unmapped reads give zero
		state_d.rdata = tft_timing_pkg::REG_RESET;
		if (reg_re) begin
			unique case (reg_addr)
			tft_timing_pkg::OFS_PANEL_TYPE: begin
				state_d.rdata[1:0] = state_q.panel_type;
				state_d.rdata[tft_timing_pkg::POS_DIRECT] =
					state_q.direct_mode;
			end
			tft_timing_pkg::OFS_HTOTAL: begin
				state_d.rdata[6:0] = state_q.htotal_f;
			end
			tft_timing_pkg::OFS_HDISP_PERIOD: begin
				state_d.rdata[6:0] = state_q.hdisp_period_f;
			end
			tft_timing_pkg::OFS_HDISP_START: begin
				state_d.rdata[9:0] = state_q.hdisp_start_f;
			end
			tft_timing_pkg::OFS_HSYNC: begin
				state_d.rdata[9:0] = state_q.hsync_start_f;
				state_d.rdata[tft_timing_pkg::POS_WIDTH +: 7] =
					state_q.hsync_width_f;
				state_d.rdata[tft_timing_pkg::POS_POLARITY] =
					state_q.hsync_pol;
			end
			tft_timing_pkg::OFS_VTOTAL: begin
				state_d.rdata[9:0] = state_q.vtotal_f;
			end
			tft_timing_pkg::OFS_VDISP_PERIOD: begin
				state_d.rdata[9:0] = state_q.vdisp_period_f;
			end
			tft_timing_pkg::OFS_VDISP_START: begin
				state_d.rdata[9:0] = state_q.vdisp_start_f;
			end
			tft_timing_pkg::OFS_VSYNC: begin
				state_d.rdata[9:0] = state_q.vsync_start_f;
				state_d.rdata[tft_timing_pkg::POS_WIDTH +: 3] =
					state_q.vsync_width_f;
				state_d.rdata[tft_timing_pkg::POS_POLARITY] =
					state_q.vsync_pol;
			end
			tft_timing_pkg::OFS_STATUS: begin
				state_d.rdata[11:0] = state_q.hcnt;
				state_d.rdata[tft_timing_pkg::POS_LINE_STAT +: 12] =
					state_q.vcnt;
			end
			default: begin
			end
			endcase
		end

		// Timing engine, one step per pixel clock rise
		if (!tft_on) begin
			// Idle panel: counters parked, syncs inactive
			state_d.hcnt  = 12'h000;
			state_d.vcnt  = 12'h000;
			state_d.hsync = ~state_q.hsync_pol;
			state_d.vsync = ~state_q.vsync_pol;
			state_d.de    = 1'b0;
			state_d.aux   = 4'h0;
		end else if (pix_tick) begin
			// Counters wrap at the totals; a shrinking total that
			// leaves a counter past its end restarts it at zero
			if (state_q.hcnt + 12'h001 >= h_total) begin
				state_d.hcnt = 12'h000;
				if (state_q.vcnt + 12'h001 >= v_total) begin
					state_d.vcnt = 12'h000;
				end else begin
					state_d.vcnt = state_q.vcnt + 12'h001;
				end
			end else begin
				state_d.hcnt = state_q.hcnt + 12'h001;
			end

			// Hsync every line, active for its width
			act_h = in_win(state_q.hcnt, h_sync_at,
				h_sync_len, h_total);
			// Vsync whole lines from line hcnt 0, so its edge leads the
			// hsync edge by the sync start
			act_v = in_win(state_q.vcnt, 12'(state_q.vsync_start_f),
				12'(state_q.vsync_width_f) + 12'h001, v_total);
			state_d.hsync = act_h ^ ~state_q.hsync_pol;
			state_d.vsync = act_v ^ ~state_q.vsync_pol;

			// Data enable from display start for the display width;
			// the wrapped window gives the after-sync delay and the
			// trailing gap; keeping the delay under 250 is software's
			vis_v = in_win(state_q.vcnt, 12'(state_q.vdisp_start_f),
				12'(state_q.vdisp_period_f) + 12'h001, v_total);
			state_d.de = vis_v & in_win(state_q.hcnt, h_de_at,
				h_de_len, h_total);

			// Direct reflective panel side pulses
			if (state_q.direct_mode) begin
				alt1 = in_win(v_line, tft_timing_pkg::AUX1_ALT_LINE,
					tft_timing_pkg::AUX1_ALT_LINES, v_total);
				alt0 = in_win(v_line, tft_timing_pkg::AUX0_ALT_LINE,
					tft_timing_pkg::AUX0_ALT_LINES, v_total);
				if (alt1) begin
					// Two pulses, the gap counted between them
					a1 = in_win(state_q.hcnt, aux_at,
						tft_timing_pkg::AUX1_ALT_WIDTH, h_total)
					   | in_win(state_q.hcnt,
						shift_pos(aux_at,
						tft_timing_pkg::AUX1_ALT_WIDTH
						+ tft_timing_pkg::AUX1_ALT_GAP,
						12'h000, h_total),
						tft_timing_pkg::AUX1_ALT_WIDTH, h_total);
				end else begin
					a1 = in_win(state_q.hcnt, aux_at,
						tft_timing_pkg::AUX_MAIN_WIDTH, h_total);
				end
				if (alt0) begin
					a0 = ~in_win(state_q.hcnt, aux_at,
						tft_timing_pkg::AUX0_ALT_WIDTH, h_total);
				end else begin
					a0 = ~in_win(state_q.hcnt, aux_at,
						tft_timing_pkg::AUX_MAIN_WIDTH, h_total);
				end
				state_d.aux[0] = a0;
				state_d.aux[1] = a1;
				if (state_q.hcnt == shift_pos(h_rise, 12'h000,
					tft_timing_pkg::AUX2_LEAD, h_total)) begin
					state_d.aux[2] = ~state_q.aux[2];
				end
				state_d.aux[3] = in_win(state_q.hcnt,
					shift_pos(h_rise, tft_timing_pkg::AUX3_DELAY,
					12'h000, h_total),
					tft_timing_pkg::AUX3_WIDTH, h_total);
			end else begin
				state_d.aux = 4'h0;
			end
		end
	end

	// ********************************************************
	// Registers
	// ********************************************************
	// Constant reset image; fields clear, timing idle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	// All straight from flip-flops; syncs read low while in reset
	assign reg_rdata           = state_q.rdata;
	assign horizontal_sync_out = state_q.hsync;
	assign vertical_sync_out   = state_q.vsync;
	assign data_enable_out     = state_q.de;
	assign panel_shift_clock   = state_q.shift;
	assign aux_control_0       = state_q.aux[0];
	assign aux_control_1       = state_q.aux[1];
	assign aux_control_2       = state_q.aux[2];
	assign aux_control_3       = state_q.aux[3];

endmodule

// [testbench/tft_timing_asserts.sv]
// Purpose: Port-level timing checks for the TFT timing generator.
// Assumes: Geometry is rewritten only while panel timing is off.
// Notes:   cnt_q counts shift clock rises since the last line sync fall.
`timescale 1ns/10ps

module tft_timing_asserts (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_we,
	input wire logic        reg_re,
	input wire logic [31:0] reg_rdata,
	input wire logic        pixel_clock_in,
	input wire logic        horizontal_sync_out,
	input wire logic        vertical_sync_out,
	input wire logic        data_enable_out,
	input wire logic        panel_shift_clock,
	input wire logic        aux_control_0,
	input wire logic        aux_control_1,
	input wire logic        aux_control_2,
	input wire logic        aux_control_3
);
	// ****************************************
	// Shadow fields and counters
	// ****************************************
	logic [6:0] ht_f_q, hw_f_q, hdp_f_q;
	logic [9:0] hs_f_q, hds_f_q, vt_f_q;
	logic [2:0] vw_f_q;
	logic [1:0] type_q;
	logic       h_q, v_q, s_q, armed_q, varmed_q;
	int         cnt_q, lcnt_q, ht, hs, hw, hds, hdisplay_period;

	// Geometry as the panel sees it
	assign ht  = (ht_f_q + 1) * 8;
	assign hs  = hs_f_q + 1;
	assign hw  = hw_f_q + 1;
	assign hds = hds_f_q + 5;
	assign hdisplay_period = (hdp_f_q + 1) * 8;

	// Edge history resets low, the reset level of every output
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{h_q, v_q, s_q, armed_q, varmed_q, type_q} <= '0;
			{ht_f_q, hw_f_q, hdp_f_q, hs_f_q, hds_f_q} <= '0;
			{vt_f_q, vw_f_q} <= '0;
			cnt_q <= 0;
			lcnt_q <= 0;
		end else begin
			h_q <= horizontal_sync_out;
			v_q <= vertical_sync_out;
			s_q <= panel_shift_clock;
			if (reg_we) begin
				case (reg_addr)
				tft_timing_pkg::OFS_PANEL_TYPE:   type_q <= reg_wdata[1:0];
				tft_timing_pkg::OFS_HTOTAL:       ht_f_q <= reg_wdata[6:0];
				tft_timing_pkg::OFS_HDISP_PERIOD: hdp_f_q <= reg_wdata[6:0];
				tft_timing_pkg::OFS_HDISP_START:  hds_f_q <= reg_wdata[9:0];
				tft_timing_pkg::OFS_HSYNC: begin
					hs_f_q <= reg_wdata[9:0];
					hw_f_q <= reg_wdata[22:16];
				end
				tft_timing_pkg::OFS_VTOTAL:       vt_f_q <= reg_wdata[9:0];
				tft_timing_pkg::OFS_VSYNC:        vw_f_q <= reg_wdata[18:16];
				default: ;
				endcase
			end
			if (h_q && !horizontal_sync_out) begin
				cnt_q <= 1;
				armed_q <= 1'b1;
				lcnt_q <= lcnt_q + 1;
			end else if (!s_q && panel_shift_clock)
				cnt_q <= cnt_q + 1;
			if (v_q && !vertical_sync_out) begin
				lcnt_q <= 0;
				varmed_q <= 1'b1;
			end
			// Polarity flips while off fake sync edges, so disarm
			if (type_q != tft_timing_pkg::PANEL_TFT) begin
				armed_q <= 1'b0;
				varmed_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence shift_high_s;
		panel_shift_clock [*8];
	endsequence
	sequence line_fall_s;
		armed_q && $fell(horizontal_sync_out);
	endsequence

	a_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
		else $error("read data outside its slot");
	a_shift_half: assert property ($rose(panel_shift_clock) |=> shift_high_s)
		else $error("shift clock high half too short");
	a_line_period: assert property (line_fall_s |-> cnt_q == ht)
		else $error("line period wrong");
	a_hsync_width: assert property (armed_q && $rose(horizontal_sync_out)
		|-> cnt_q == hw) else $error("line sync width wrong");
	a_de_delay: assert property (armed_q && $rose(data_enable_out)
		|-> cnt_q == hds - hs) else $error("enable start wrong");
	a_de_width: assert property (armed_q && $fell(data_enable_out)
		|-> cnt_q == hds - hs + hdisplay_period) else $error("enable width wrong");
	a_vsync_phase: assert property (armed_q && $fell(vertical_sync_out)
		|-> cnt_q == ht - hs) else $error("frame sync phase wrong");
	a_frame_period: assert property (varmed_q && $fell(vertical_sync_out)
		|-> lcnt_q == vt_f_q + 1) else $error("frame length wrong");
	a_vsync_lines: assert property (varmed_q && $rose(vertical_sync_out)
		|-> lcnt_q == vw_f_q + 1) else $error("frame sync width wrong");
	a_aux3_delay: assert property (armed_q && $rose(aux_control_3)
		|-> cnt_q == hw + 4) else $error("aux 3 position wrong");
	a_aux2_toggle: assert property (armed_q && $changed(aux_control_2)
		|-> cnt_q == (hw + ht - 11) % ht + 1) else $error("aux 2 toggle wrong");
	a_aux_pair: assert property (armed_q && $fell(aux_control_0)
		|-> $rose(aux_control_1) && cnt_q == hw - 4)
		else $error("aux 0 and aux 1 out of step");
	a_aux1_width: assert property (armed_q && $fell(aux_control_1)
		|-> cnt_q == (hw + 131) % ht + 1 || cnt_q == hw + 44)
		else $error("aux 1 width wrong");
endmodule

// [testbench/tft_panel_model.sv]
// Purpose: Panel stand-in: makes the pixel clock and watches frames.
// Assumes: Syncs programmed active low while the model counts.
// Notes:   A panel's pixel clock runs free, so it never stops here.
`timescale 1ns/10ps

module tft_panel_model (
	output logic       pixel_clock_in,
	input  wire logic  horizontal_sync_out,
	input  wire logic  vertical_sync_out,
	input  wire logic  data_enable_out,
	input  wire logic  panel_shift_clock,
	output logic [7:0] frames,
	output logic [7:0] first_de_line,
	output logic [7:0] de_lines
);
	// ****************************************
	// Pixel clock and frame watcher
	// ****************************************
	logic [7:0] line = 8'h0;
	logic [7:0] n_de = 8'h0;
	logic       h_q = 1'b1;
	logic       v_q = 1'b1;
	logic       de_q = 1'b0;

	// Odd start offset keeps the phase unrelated to sys_clk
	initial begin
		frames = 8'h0;
		first_de_line = 8'h0;
		de_lines = 8'h0;
		pixel_clock_in = 1'b0;
		#37;
		forever #80 pixel_clock_in = ~pixel_clock_in;
	end

	// Panel latches on the shift clock fall, syncs active low
	always @(negedge panel_shift_clock) begin
		h_q <= horizontal_sync_out;
		v_q <= vertical_sync_out;
		de_q <= data_enable_out;
		if (v_q && !vertical_sync_out) begin
			frames <= frames + 8'h1;
			de_lines <= n_de;
			n_de <= 8'h0;
			line <= 8'h0;
		end else if (h_q && !horizontal_sync_out)
			line <= line + 8'h1;
		if (!de_q && data_enable_out) begin
			n_de <= n_de + 8'h1;
			if (n_de == 8'h0)
				first_de_line <= line - 8'h1;
		end
	end
endmodule

// [testbench/tft_panel_timing_generator_test.sv]
// Purpose: Register and panel timing tests for the TFT timing generator.
// Assumes: Line 144 pixels, frame 10 lines; one frame fits the run.
// Notes:   Alternate aux 0 lines lie past a 10-line frame, left unseen.
`timescale 1ns/10ps

module tft_panel_timing_generator_test;
	logic        sys_clk, rst, reg_we, reg_re, pixel_clock_in;
	logic [7:0]  reg_addr, frames, first_de_line, de_lines;
	logic [31:0] reg_wdata, reg_rdata;
	logic        horizontal_sync_out, vertical_sync_out;
	logic        data_enable_out, panel_shift_clock;
	logic        aux_control_0, aux_control_1, aux_control_2, aux_control_3;
	int          miscompares = 0;
	int          num_checks = 0;
	int          cycles = 0;

	tft_panel_timing_generator tft_panel_timing_generator_inst (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .pixel_clock_in(pixel_clock_in),
		.horizontal_sync_out(horizontal_sync_out),
		.vertical_sync_out(vertical_sync_out),
		.data_enable_out(data_enable_out),
		.panel_shift_clock(panel_shift_clock),
		.aux_control_0(aux_control_0), .aux_control_1(aux_control_1),
		.aux_control_2(aux_control_2), .aux_control_3(aux_control_3));
	tft_panel_model tft_panel_model_inst (
		.pixel_clock_in(pixel_clock_in),
		.horizontal_sync_out(horizontal_sync_out),
		.vertical_sync_out(vertical_sync_out),
		.data_enable_out(data_enable_out),
		.panel_shift_clock(panel_shift_clock), .frames(frames),
		.first_de_line(first_de_line), .de_lines(de_lines));

	// ****************************************
	// Clock, timeout and access tasks
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// One frame is about 46k cycles; allow margin, no more
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] e,
			input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge sys_clk);
		reg_we <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge sys_clk);
		reg_re <= 1'b0;
		#1;
		chk("reg_rdata", e, reg_rdata);
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		{rst, reg_we, reg_re, reg_addr, reg_wdata} <= {3'h4, 40'h0};
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rd(tft_timing_pkg::OFS_PANEL_TYPE, 32'h0);
		for (int i = 0; i < 9; i++)
			rd(tft_timing_pkg::OFS_HTOTAL + 8'(i * 4), 32'h0);
		// Reserved bits must read back as zero
		wr(tft_timing_pkg::OFS_HDISP_PERIOD, 32'hffffffff);
		rd(tft_timing_pkg::OFS_HDISP_PERIOD, 32'h0000007f);
		wr(tft_timing_pkg::OFS_HSYNC, 32'hffffffff);
		rd(tft_timing_pkg::OFS_HSYNC, 32'h00ff03ff);
		wr(tft_timing_pkg::OFS_VSYNC, 32'hffffffff);
		rd(tft_timing_pkg::OFS_VSYNC, 32'h008703ff);
		wr(8'h10, 32'hffffffff);
		rd(8'h10, 32'h0);
		// Line 144, sync 10..17, enable 20..99; frame 10, rows 2..6
		wr(tft_timing_pkg::OFS_HTOTAL, 32'h11);
		wr(tft_timing_pkg::OFS_HDISP_PERIOD, 32'h9);
		wr(tft_timing_pkg::OFS_HDISP_START, 32'hf);
		wr(tft_timing_pkg::OFS_HSYNC, 32'h00070009);
		wr(tft_timing_pkg::OFS_VTOTAL, 32'h9);
		wr(tft_timing_pkg::OFS_VDISP_PERIOD, 32'h4);
		wr(tft_timing_pkg::OFS_VDISP_START, 32'h2);
		wr(tft_timing_pkg::OFS_VSYNC, 32'h00010000);
		rd(tft_timing_pkg::OFS_HTOTAL, 32'h11);
		wr(tft_timing_pkg::OFS_PANEL_TYPE, 32'h11);
		rd(tft_timing_pkg::OFS_PANEL_TYPE, 32'h11);
		while (frames < 8'h2)
			@(posedge sys_clk);
		chk("first_de_line", 32'h2, {24'h0, first_de_line});
		chk("de_lines", 32'h5, {24'h0, de_lines});
		// Switch off mid-frame with each non-panel code
		for (int t = 0; t < 4; t++) begin
			if (t != 1) begin
				@(negedge panel_shift_clock);
				wr(tft_timing_pkg::OFS_PANEL_TYPE, 32'(t));
				repeat (100) @(posedge sys_clk);
				chk("idle_outputs", 32'hc0, {24'h0, horizontal_sync_out,
					vertical_sync_out, data_enable_out, panel_shift_clock,
					aux_control_0, aux_control_1, aux_control_2,
					aux_control_3});
				wr(tft_timing_pkg::OFS_PANEL_TYPE, 32'h11);
				repeat (200) @(posedge sys_clk);
			end
		end
		stop_test();
	end
endmodule

bind tft_panel_timing_generator tft_timing_asserts tft_timing_asserts_inst (
	.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
	.reg_rdata(reg_rdata), .pixel_clock_in(pixel_clock_in),
	.horizontal_sync_out(horizontal_sync_out),
	.vertical_sync_out(vertical_sync_out),
	.data_enable_out(data_enable_out),
	.panel_shift_clock(panel_shift_clock),
	.aux_control_0(aux_control_0), .aux_control_1(aux_control_1),
	.aux_control_2(aux_control_2), .aux_control_3(aux_control_3));
